// ---- design/input_sync.sv ----
`timescale 1ns/1ps
module input_sync
  import servo_sel_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [servo_sel_pkg::SYNC_W-1:0] async_i,
  output logic [servo_sel_pkg::SYNC_W-1:0] sync_o
);

  typedef struct packed {
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
  } sync_state_type;

  sync_state_type state;
  sync_state_type next_state;

  // Inputs idle high, so reset to the inactive level of the low-true lines.
  always_comb
  begin
    next_state = state;
    next_state.stage1 = async_i;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state.stage1 <= '1;
      state.stage2 <= '1;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign sync_o = state.stage2;

endmodule : input_sync

// ---- design/servo_enable_mode_select.sv ----
// Functional notes
// - Mode 0 selects analog speed control.
// - Mode 1 selects pulse train position control.
// - Mode 2 selects analog torque control.
// - Mode 3 picks preset speeds from contacts.
// - Modes 4 and up switch between methods.
// - Enable low powers motor, high removes it.
// - Enable source 0 uses external input.
// - Enable source 1 powers after ready.
// - Enable source change waits for power cycle.
// - Enable input connector is reassignable.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module servo_enable_mode_select
  import servo_sel_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [servo_sel_pkg::ADDR_W-1:0] addr_i,
  input wire logic [servo_sel_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [servo_sel_pkg::DATA_W-1:0] rdata_o,
  input wire logic power_cycle_i,
  input wire logic ready_cond_i,
  input wire logic [servo_sel_pkg::CONN_W-1:0] connector_n_i,
  input wire logic proportional_select_n_i,
  input wire logic fwd_limit_select_n_i,
  input wire logic rev_limit_select_n_i,
  output logic servo_ready_o,
  output logic motor_power_o,
  output logic speed_ctrl_o,
  output logic position_ctrl_o,
  output logic torque_ctrl_o,
  output logic contact_ctrl_o,
  output logic [servo_sel_pkg::SPEED_W-1:0] preset_speed_o,
  output logic ref_zero_o,
  output logic reverse_dir_o
);

  import servo_sel_pkg::*;

  typedef struct packed {
    logic [PARAM_W-1:0] basic_func;
    logic [PARAM_W-1:0] app_func;
    logic [DIGIT_W-1:0] enable_src;
    logic [MAP_W-1:0] enable_map;
    logic [SPEED_W-1:0] preset1;
    logic [SPEED_W-1:0] preset2;
    logic [SPEED_W-1:0] preset3;
    logic ready;
    power_state_type power;
    ctrl_class_type ctrl_class;
    logic [SPEED_W-1:0] speed;
    logic ref_zero;
    logic reverse_dir;
    logic [DATA_W-1:0] rdata;
  } main_state_type;

  main_state_type state;
  main_state_type next_state;

  logic [SYNC_W-1:0] raw_inputs;
  logic [SYNC_W-1:0] sync_inputs;
  logic [CONN_W-1:0] conn_n;
  logic pcon_n;
  logic pcl_n;
  logic ncl_n;
  logic enable_n;
  logic [DIGIT_W-1:0] mode_digit;

  assign raw_inputs = {proportional_select_n_i, fwd_limit_select_n_i,
                       rev_limit_select_n_i, connector_n_i};

  input_sync sync_inst (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .async_i(raw_inputs),
    .sync_o(sync_inputs)
  );

  assign conn_n = sync_inputs[CONN_W-1:0];
  assign ncl_n = sync_inputs[CONN_W];
  assign pcl_n = sync_inputs[CONN_W+1];
  assign pcon_n = sync_inputs[CONN_W+2];
  assign enable_n = conn_n[state.enable_map];
  assign mode_digit = state.app_func[CTRL_MODE_LSB +: DIGIT_W];

  // Switching modes pair two methods; the proportional select contact picks
  // the second one while held low, so it no longer steers direction.
  function automatic ctrl_class_type pick_class(
    input logic [DIGIT_W-1:0] digit,
    input logic second
  );
    ctrl_class_type result;
    result = CLASS_SPEED;
    if (digit == MODE_SPEED)
      result = CLASS_SPEED;
    else if (digit == MODE_POSITION)
      result = CLASS_POSITION;
    else if (digit == MODE_TORQUE)
      result = CLASS_TORQUE;
    else if (digit == MODE_CONTACT)
      result = CLASS_CONTACT;
    else if (digit == MODE_CONTACT_SPEED)
      result = second ? CLASS_SPEED : CLASS_CONTACT;
    else if (digit == MODE_CONTACT_POSITION)
      result = second ? CLASS_POSITION : CLASS_CONTACT;
    else if (digit == MODE_CONTACT_TORQUE)
      result = second ? CLASS_TORQUE : CLASS_CONTACT;
    else if (digit == MODE_POSITION_SPEED)
      result = second ? CLASS_SPEED : CLASS_POSITION;
    else if (digit == MODE_POSITION_TORQUE)
      result = second ? CLASS_TORQUE : CLASS_POSITION;
    else if (digit == MODE_TORQUE_SPEED)
      result = second ? CLASS_SPEED : CLASS_TORQUE;
    else
      result = second ? CLASS_SPEED : CLASS_CONTACT;
    return result;
  endfunction : pick_class

  always_comb
  begin
    next_state = state;
    next_state.rdata = RDATA_RST;

    if (wr_i)
    begin
      if (addr_i == BASIC_FUNC_OFS)
        next_state.basic_func = wdata_i[PARAM_W-1:0];
      else if (addr_i == APP_FUNC_OFS)
        next_state.app_func = wdata_i[PARAM_W-1:0];
      else if (addr_i == ENABLE_MAP_OFS)
        next_state.enable_map = wdata_i[MAP_W-1:0];
      else if (addr_i == PRESET1_OFS)
        next_state.preset1 = wdata_i[SPEED_W-1:0];
      else if (addr_i == PRESET2_OFS)
        next_state.preset2 = wdata_i[SPEED_W-1:0];
      else if (addr_i == PRESET3_OFS)
        next_state.preset3 = wdata_i[SPEED_W-1:0];
    end

    if (rd_i)
    begin
      if (addr_i == BASIC_FUNC_OFS)
        next_state.rdata[PARAM_W-1:0] = state.basic_func;
      else if (addr_i == APP_FUNC_OFS)
        next_state.rdata[PARAM_W-1:0] = state.app_func;
      else if (addr_i == ENABLE_MAP_OFS)
        next_state.rdata[MAP_W-1:0] = state.enable_map;
      else if (addr_i == PRESET1_OFS)
        next_state.rdata[SPEED_W-1:0] = state.preset1;
      else if (addr_i == PRESET2_OFS)
        next_state.rdata[SPEED_W-1:0] = state.preset2;
      else if (addr_i == PRESET3_OFS)
        next_state.rdata[SPEED_W-1:0] = state.preset3;
      else if (addr_i == STATUS_OFS)
      begin
        next_state.rdata[ST_POWER_BIT] = (state.power == PWR_ON);
        next_state.rdata[ST_READY_BIT] = state.ready;
        next_state.rdata[ST_CLASS_LSB +: 4] = state.ctrl_class;
        next_state.rdata[ST_ZERO_BIT] = state.ref_zero;
        next_state.rdata[ST_DIR_BIT] = state.reverse_dir;
        next_state.rdata[ST_SRC_LSB +: DIGIT_W] = state.enable_src;
        next_state.rdata[ST_ENABLE_BIT] = enable_n;
      end
    end

    // Turning on automatically at power-up is a hazard, so the stored digit
    // only becomes live when the supplies are cycled.
    if (power_cycle_i)
      next_state.enable_src =
        state.basic_func[ENABLE_SRC_LSB +: DIGIT_W];

    next_state.ready = ready_cond_i;

    case (state.power)
      PWR_OFF:
      begin
        if (state.enable_src == ENABLE_SRC_AUTO)
        begin
          if (state.ready)
            next_state.power = PWR_ON;
        end
        else if (!enable_n)
          next_state.power = PWR_ON;
      end
      PWR_ON:
      begin
        if (state.enable_src == ENABLE_SRC_AUTO)
        begin
          if (!state.ready)
            next_state.power = PWR_OFF;
        end
        else if (enable_n)
          next_state.power = PWR_OFF;
      end
      default:
        next_state.power = PWR_OFF;
    endcase

    next_state.ctrl_class = pick_class(mode_digit, !pcon_n);

    // Limit select contacts choose one of three presets or zero reference.
    next_state.ref_zero = 1'b0;
    next_state.speed = PRESET_RST;
    if (pick_class(mode_digit, !pcon_n) == CLASS_CONTACT)
    begin
      if (!pcl_n && !ncl_n)
        next_state.speed = state.preset3;
      else if (!ncl_n)
        next_state.speed = state.preset2;
      else if (!pcl_n)
        next_state.speed = state.preset1;
      else
        next_state.ref_zero = 1'b1;
    end
    next_state.reverse_dir = (mode_digit == MODE_CONTACT) && !pcon_n;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state.basic_func <= BASIC_FUNC_RST;
      state.app_func <= APP_FUNC_RST;
      state.enable_src <= ENABLE_SRC_EXTERNAL;
      state.enable_map <= ENABLE_MAP_RST;
      state.preset1 <= PRESET_RST;
      state.preset2 <= PRESET_RST;
      state.preset3 <= PRESET_RST;
      state.ready <= 1'b0;
      state.power <= PWR_OFF;
      state.ctrl_class <= CLASS_SPEED;
      state.speed <= PRESET_RST;
      state.ref_zero <= 1'b0;
      state.reverse_dir <= 1'b0;
      state.rdata <= RDATA_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  // The host must not use the enable to start or stop a moving reference;
  // this block drops power at once and offers no soft stop.
  assign motor_power_o = (state.power == PWR_ON);
  assign servo_ready_o = state.ready;
  assign speed_ctrl_o = (state.ctrl_class == CLASS_SPEED);
  assign position_ctrl_o = (state.ctrl_class == CLASS_POSITION);
  assign torque_ctrl_o = (state.ctrl_class == CLASS_TORQUE);
  assign contact_ctrl_o = (state.ctrl_class == CLASS_CONTACT);
  assign preset_speed_o = state.speed;
  assign ref_zero_o = state.ref_zero;
  assign reverse_dir_o = state.reverse_dir;
  assign rdata_o = state.rdata;

endmodule : servo_enable_mode_select

// ---- design/servo_sel_pkg.sv ----
package servo_sel_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PARAM_W = 16;
  localparam int DIGIT_W = 4;
  localparam int CONN_W = 8;
  localparam int MAP_W = 3;
  localparam int SPEED_W = 16;
  localparam int SYNC_W = CONN_W + 3;

  localparam logic [ADDR_W-1:0] BASIC_FUNC_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] APP_FUNC_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] ENABLE_MAP_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] PRESET1_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] PRESET2_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] PRESET3_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h18;

  localparam logic [PARAM_W-1:0] BASIC_FUNC_RST = 16'h0000;
  localparam logic [PARAM_W-1:0] APP_FUNC_RST = 16'h0000;
  localparam logic [MAP_W-1:0] ENABLE_MAP_RST = 3'h0;
  localparam logic [SPEED_W-1:0] PRESET_RST = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  localparam int ENABLE_SRC_LSB = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam logic [DIGIT_W-1:0] ENABLE_SRC_EXTERNAL = 4'h0;
  localparam logic [DIGIT_W-1:0] ENABLE_SRC_AUTO = 4'h1;

  localparam logic [DIGIT_W-1:0] MODE_SPEED = 4'h0;
  localparam logic [DIGIT_W-1:0] MODE_POSITION = 4'h1;
  localparam logic [DIGIT_W-1:0] MODE_TORQUE = 4'h2;
  localparam logic [DIGIT_W-1:0] MODE_CONTACT = 4'h3;
  localparam logic [DIGIT_W-1:0] MODE_CONTACT_SPEED = 4'h4;
  localparam logic [DIGIT_W-1:0] MODE_CONTACT_POSITION = 4'h5;
  localparam logic [DIGIT_W-1:0] MODE_CONTACT_TORQUE = 4'h6;
  localparam logic [DIGIT_W-1:0] MODE_POSITION_SPEED = 4'h7;
  localparam logic [DIGIT_W-1:0] MODE_POSITION_TORQUE = 4'h8;
  localparam logic [DIGIT_W-1:0] MODE_TORQUE_SPEED = 4'h9;

  localparam int ST_POWER_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_CLASS_LSB = 2;
  localparam int ST_ZERO_BIT = 6;
  localparam int ST_DIR_BIT = 7;
  localparam int ST_SRC_LSB = 8;
  localparam int ST_ENABLE_BIT = 12;

  typedef enum logic [3:0] {
    CLASS_SPEED = 4'b0001,
    CLASS_POSITION = 4'b0010,
    CLASS_TORQUE = 4'b0100,
    CLASS_CONTACT = 4'b1000
  } ctrl_class_type;

  typedef enum logic [1:0] {
    PWR_OFF = 2'b01,
    PWR_ON = 2'b10
  } power_state_type;

endpackage : servo_sel_pkg

// ---- testbench/host_enable_model.sv ----
`timescale 1ns/1ps
module host_enable_model
  import servo_sel_pkg::*;
(
  input wire logic clk_i,
  input wire logic en_req_i,
  input wire logic [servo_sel_pkg::MAP_W-1:0] map_i,
  input wire logic [servo_sel_pkg::CONN_W-1:0] stray_i,
  output logic [servo_sel_pkg::CONN_W-1:0] connector_n_o
);
  initial connector_n_o = '1;
  // Only connector lines are driven, the enable and stray bits, so no reference ever precedes it.
  always @(posedge clk_i)
  begin
    connector_n_o <= ~((CONN_W'(en_req_i) << map_i) | stray_i);
  end
endmodule : host_enable_model

// ---- testbench/servo_enable_mode_select_tb.sv ----
`timescale 1ns/1ps
module servo_enable_mode_select_tb;
  import servo_sel_pkg::*;
  logic clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, power_cycle_i = 0;
  logic ready_cond_i = 1, en = 0, proportional_select_n_i = 1;
  logic fwd_limit_select_n_i = 1, rev_limit_select_n_i = 1;
  logic [7:0] addr_i = 0, stray = 0, connector_n_i;
  logic [31:0] wdata_i = 0, rdata_o;
  logic [2:0] map_sel = 0;
  logic servo_ready_o, motor_power_o, speed_ctrl_o, position_ctrl_o;
  logic torque_ctrl_o, contact_ctrl_o, ref_zero_o, reverse_dir_o;
  logic [15:0] preset_speed_o;
  logic [15:0] pre_m [3] = '{default: 0};
  int errors = 0, n_compared = 0, app_m = 0, basic_m = 0, live_m = 0;
  int map_m = 0;
  int fst [16] = '{0, 1, 2, 3, 3, 3, 3, 1, 1, 2, 3, 3, 3, 3, 3, 3};
  int snd [16] = '{0, 1, 2, 3, 0, 1, 2, 0, 2, 0, 0, 0, 0, 0, 0, 0};
  servo_enable_mode_select u_servo_enable_mode_select (.clk_i, .rstn_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .power_cycle_i,
    .ready_cond_i, .connector_n_i, .proportional_select_n_i,
    .fwd_limit_select_n_i, .rev_limit_select_n_i, .servo_ready_o,
    .motor_power_o, .speed_ctrl_o, .position_ctrl_o, .torque_ctrl_o,
    .contact_ctrl_o, .preset_speed_o, .ref_zero_o, .reverse_dir_o);
  host_enable_model u_host_enable_model (.clk_i, .en_req_i(en),
    .map_i(map_sel), .stray_i(stray), .connector_n_o(connector_n_i));
  initial forever #2.5 clk_i = ~clk_i;
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function logic [31:0] reg_exp(input logic [7:0] a);
    case (a)
      8'h00: return basic_m;
      8'h04: return app_m;
      8'h08: return map_m;
      8'h0C, 8'h10, 8'h14: return pre_m[(a - 8'h0C) / 4];
      default: return 0;
    endcase
  endfunction : reg_exp
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
    case (a)
      8'h00: basic_m = d[15:0];
      8'h04: app_m = d[15:0];
      8'h08: map_m = d[2:0];
      8'h0C, 8'h10, 8'h14: pre_m[(a - 8'h0C) / 4] = d[15:0];
    endcase
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1 chk(rdata_o & m, e);
  endtask : rd
  task pcyc;
    @(posedge clk_i);
    power_cycle_i <= 1;
    @(posedge clk_i);
    power_cycle_i <= 0;
    live_m = basic_m & 15;
  endtask : pcyc
  // Four cycles clear the host, sync and output stages; direct contact inputs have one to spare, the ready input two.
  task check_out;
    int m;
    int c;
    logic [31:0] e;
    repeat (4) @(posedge clk_i);
    #1 m = (app_m >> 4) & 15;
    c = proportional_select_n_i ? fst[m] : snd[m];
    e = 0;
    e[1 + c] = 1;
    if (c == 3 && !fwd_limit_select_n_i && !rev_limit_select_n_i)
      e[31:16] = pre_m[2];
    else if (c == 3 && !rev_limit_select_n_i)
      e[31:16] = pre_m[1];
    else if (c == 3 && !fwd_limit_select_n_i)
      e[31:16] = pre_m[0];
    else if (c == 3)
      e[5] = 1;
    e[6] = (m == 3) && !proportional_select_n_i;
    e[7] = ready_cond_i;
    e[0] = (live_m == 1) ? ready_cond_i : !connector_n_i[map_m];
    chk({preset_speed_o, 8'h0, servo_ready_o, reverse_dir_o, ref_zero_o,
      contact_ctrl_o, torque_ctrl_o, position_ctrl_o, speed_ctrl_o,
      motor_power_o}, e);
  endtask : check_out
  initial
  begin
    repeat (20000) @(posedge clk_i);
    errors++;
    print_verdict;
  end
  initial
  begin
    void'($urandom(45843));
    repeat (5) @(posedge clk_i);
    rstn_i <= 1;
    for (int a = 0; a < 32; a += 4)
    begin
      if (a != 24)
        rd(a, 32'hFFFF_FFFF, 0);
      wr(a, $urandom);
      if (a != 24)
        rd(a, 32'hFFFF_FFFF, reg_exp(a));
    end
    $display("test registers done");
    map_sel <= map_m;
    en <= 1;
    for (int k = 0; k < 128; k++)
    begin
      wr(8'h04, {k[6:3], 4'h0});
      proportional_select_n_i <= k[2];
      fwd_limit_select_n_i <= k[1];
      rev_limit_select_n_i <= k[0];
      check_out;
    end
    $display("test modes done");
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h08, i);
      map_sel <= i;
      en <= 1;
      stray <= 0;
      check_out;
      en <= 0;
      stray <= ~(8'h01 << i);
      check_out;
      stray <= 8'hFF;
      en <= 1;
      check_out;
    end
    $display("test enable done");
    en <= 0;
    stray <= 0;
    wr(8'h00, 1);
    check_out;
    rd(8'h18, 32'h0000_0F03, 32'h0000_0002);
    pcyc;
    check_out;
    rd(8'h18, 32'h0000_0F03, 32'h0000_0103);
    @(posedge clk_i);
    ready_cond_i <= 0;
    en <= 1;
    check_out;
    en <= 0;
    check_out;
    $display("test source done");
    print_verdict;
  end
endmodule : servo_enable_mode_select_tb

// ---- testbench/servo_sel_props.sv ----
`timescale 1ns/1ps
module servo_sel_props
  import servo_sel_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ready_cond_i,
  input wire logic [servo_sel_pkg::CONN_W-1:0] connector_n_i,
  input wire logic fwd_limit_select_n_i,
  input wire logic rev_limit_select_n_i,
  input wire logic servo_ready_o,
  input wire logic motor_power_o,
  input wire logic speed_ctrl_o,
  input wire logic position_ctrl_o,
  input wire logic torque_ctrl_o,
  input wire logic contact_ctrl_o,
  input wire logic [servo_sel_pkg::SPEED_W-1:0] preset_speed_o,
  input wire logic ref_zero_o,
  input wire logic reverse_dir_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // Both enable sources agree when every connector and ready match.
  sequence s_all_off;
    (&connector_n_i && !ready_cond_i) [*3];
  endsequence
  sequence s_all_on;
    (connector_n_i == '0 && ready_cond_i) [*3];
  endsequence
  sequence s_no_contact;
    (fwd_limit_select_n_i && rev_limit_select_n_i) [*3] ##1 contact_ctrl_o;
  endsequence
  a_power_drops: assert property (s_all_off |=> !motor_power_o)
    else $error("motor powered with enable and ready off");
  a_power_rises: assert property (s_all_on |=> motor_power_o)
    else $error("motor unpowered with enable and ready on");
  a_ready_follow: assert property (ready_cond_i |=> servo_ready_o)
    else $error("ready output missed");
  a_class_onehot: assert property ($onehot({speed_ctrl_o,
    position_ctrl_o, torque_ctrl_o, contact_ctrl_o}))
    else $error("two control methods at once");
  a_preset_gate: assert property (!contact_ctrl_o |->
    preset_speed_o == '0)
    else $error("preset speed outside contact method");
  a_zero_gate: assert property (ref_zero_o |-> contact_ctrl_o)
    else $error("zero reference outside contact method");
  a_reverse_gate: assert property (reverse_dir_o |-> contact_ctrl_o)
    else $error("reverse outside contact method");
  a_contact_zero: assert property (s_no_contact |-> ref_zero_o)
    else $error("no zero reference with contacts released");
endmodule : servo_sel_props
bind servo_enable_mode_select servo_sel_props u_servo_sel_props (.clk_i,
  .rstn_i, .ready_cond_i, .connector_n_i, .fwd_limit_select_n_i,
  .rev_limit_select_n_i, .servo_ready_o, .motor_power_o, .speed_ctrl_o,
  .position_ctrl_o, .torque_ctrl_o, .contact_ctrl_o, .preset_speed_o,
  .ref_zero_o, .reverse_dir_o);
